// file: adc_conv_alert_ctrl.sv
// Control core of a 16-bit converter: channel, range and rate selection,
// conversion sequencing, comparator and alert/ready pin.
// Assumes config, limit, start, read and alert-response strobes come as
// one-cycle pulses from the serial interface logic on sys_clk.
`timescale 1ns/1ps
module adc_conv_alert_ctrl #(
  parameter int unsigned CONV_CLK_HZ = adc_ctrl_pkg::CLK_HZ
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  // Settings strobe and fields
  input wire logic cfg_write,
  input wire logic [2:0] input_select,
  input wire logic [2:0] gain_range_select,
  input wire logic [2:0] rate_select,
  input wire logic single_shot,
  input wire logic window_style,
  input wire logic alert_polarity,
  input wire logic alert_latch_enable,
  input wire logic [1:0] alert_queue_count,
  // Limit words, signed
  input wire logic limit_write,
  input wire logic [15:0] upper_limit_in,
  input wire logic [15:0] lower_limit_in,
  // Start and alert-clear strobes
  input wire logic op_status_start,
  input wire logic general_call_reset,
  input wire logic result_read,
  input wire logic ara_won,
  // Filter output, taken at conversion end
  input wire logic [15:0] filter_result,
  // Input switch and range
  output logic [1:0] mux_pos_q,
  output logic [1:0] mux_neg_q,
  output logic neg_to_gnd_q,
  output logic [2:0] gain_code_q,
  // Modulator clock and conversion status
  output logic modulator_clk_q,
  output logic conv_busy_q,
  output logic op_status_idle_q,
  output logic [15:0] result_q,
  // Open-drain alert pin and alert response
  output logic alert_pin_o_q,
  output logic alert_pin_oe_q,
  output logic ara_respond_q,
  output logic ara_status_q
);

  typedef struct packed {
    // Written settings and those of the running conversion
    adc_ctrl_pkg::cfg_t cfg;
    adc_ctrl_pkg::cfg_t act;
    logic [15:0] upper_limit_reg;
    logic [15:0] lower_limit_reg;
    // Sequencer and last result
    adc_ctrl_pkg::conv_state_t st;
    logic [15:0] result;
    // Comparator and ready signalling
    logic alert;
    logic above;
    logic rdy_hold;
    logic [adc_ctrl_pkg::RDY_CNT_W-1:0] rdy_cnt;
    // Oscillator tick and modulator divider
    logic [adc_ctrl_pkg::OSC_CNT_W-1:0] osc_cnt;
    logic mod_ph;
    logic mod_clk;
    // Registered copies of the top outputs
    adc_ctrl_pkg::mux_t mux;
    logic [2:0] gain;
    logic busy;
    logic idle;
    logic pin_o;
    logic pin_oe;
    logic ara_respond;
  } core_t;

  localparam core_t CORE_RESET = '{
    cfg: adc_ctrl_pkg::CFG_DEFAULT,
    act: adc_ctrl_pkg::CFG_DEFAULT,
    upper_limit_reg: adc_ctrl_pkg::UPPER_DEFAULT,
    lower_limit_reg: adc_ctrl_pkg::LOWER_DEFAULT,
    st: adc_ctrl_pkg::ST_IDLE,
    // Switch and range outputs show the power-up selection
    mux: adc_ctrl_pkg::mux_decode(adc_ctrl_pkg::CFG_DEFAULT.input_select),
    gain: adc_ctrl_pkg::CFG_DEFAULT.gain_range_select,
    idle: 1'b1,
    default: '0
  };

  core_t q;
  core_t d;
  adc_ctl_if ctl ();

  logic rdy_mode;
  logic cmp_on;
  logic above;
  logic below;
  logic asserted;
  logic do_start;
  logic latched;

  conv_timer #(.CONV_CLK_HZ(CONV_CLK_HZ)) u_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ctl(ctl.tmr)
  );

  alert_qualifier u_qual (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ctl(ctl.qual)
  );

  // Mode decode from current settings; ready signalling overrides
  // comparator style and latch but leaves polarity in force
  always_comb begin
    rdy_mode = q.upper_limit_reg[adc_ctrl_pkg::LIMIT_MSB] &&
               !q.lower_limit_reg[adc_ctrl_pkg::LIMIT_MSB];
    cmp_on = q.cfg.alert_queue_count != adc_ctrl_pkg::QUE_OFF;
    latched = q.cfg.alert_latch_enable && !rdy_mode;
    above = $signed(filter_result) > $signed(q.upper_limit_reg);
    below = $signed(filter_result) < $signed(q.lower_limit_reg);
  end

  // Requests to the timer and qualifier
  // The queue count restarts whenever the comparator is off
  assign ctl.soft_rst = general_call_reset;
  assign ctl.rate = q.cfg.rate_select;
  assign ctl.start = do_start;
  assign ctl.eval = ctl.done && !rdy_mode;
  assign ctl.outl = q.cfg.window_style ? (above || below) : above;
  assign ctl.clr = !cmp_on || rdy_mode;
  assign ctl.need = adc_ctrl_pkg::queue_need(q.cfg.alert_queue_count);

  // Next state of the whole core
  // Soft reset is applied last so it overrides every update
  always_comb begin
    d = q;
    do_start = 1'b0;
    asserted = 1'b0;
    if (cfg_write) begin
      d.cfg = '{
        input_select: input_select,
        gain_range_select: gain_range_select,
        rate_select: rate_select,
        single_shot: single_shot,
        window_style: window_style,
        alert_polarity: alert_polarity,
        alert_latch_enable: alert_latch_enable,
        alert_queue_count: alert_queue_count
      };
    end
    if (limit_write) begin
      d.upper_limit_reg = upper_limit_in;
      d.lower_limit_reg = lower_limit_in;
    end

    // Modulator clock from the 1 MHz oscillator tick
    // Runs free, whether or not a conversion is in progress
    if (q.osc_cnt == adc_ctrl_pkg::OSC_CNT_W'(adc_ctrl_pkg::OSC_DIV - 1)) begin
      d.osc_cnt = '0;
      d.mod_ph = !q.mod_ph;
      if (q.mod_ph == 1'(adc_ctrl_pkg::MOD_HALF - 1)) begin
        d.mod_clk = !q.mod_clk;
      end
    end else begin
      d.osc_cnt = q.osc_cnt + 1'b1;
    end

    // Clears of a latched alert, applied before any new set
    if (result_read || (ara_won && q.ara_respond)) begin
      d.alert = 1'b0;
    end

    // Conversion sequencing
    case (q.st)
      adc_ctrl_pkg::ST_IDLE: begin
        // Timer must be free, or a start would be lost
        if (!ctl.busy && (q.cfg.single_shot ? op_status_start : 1'b1)) begin
          do_start = 1'b1;
        end
      end
      adc_ctrl_pkg::ST_CONV: begin
        if (ctl.done) begin
          d.result = filter_result;
          d.st = adc_ctrl_pkg::ST_IDLE;
          if (!q.cfg.single_shot) begin
            do_start = 1'b1;
          end
        end
      end
      default: begin
        d.st = adc_ctrl_pkg::ST_IDLE;
      end
    endcase
    // Settings are copied only at a start, so a mid-run write waits
    if (do_start) begin
      d.act = q.cfg;
      d.st = adc_ctrl_pkg::ST_CONV;
      d.rdy_hold = 1'b0;
    end

    // Comparator on each finished result
    // A set here wins over a clear earlier in the same cycle
    if (ctl.eval && cmp_on) begin
      if (ctl.hit) begin
        d.alert = 1'b1;
        d.above = above;
      end else if (!latched) begin
        if (q.cfg.window_style ? !(above || below) : below) begin
          d.alert = 1'b0;
        end
      end
    end
    if (!cmp_on || rdy_mode) begin
      d.alert = 1'b0;
    end

    // Ready signalling
    // Continuous runs give a timed pulse, single-shot holds to next start
    if (q.rdy_cnt != '0) begin
      d.rdy_cnt = q.rdy_cnt - 1'b1;
    end
    if (ctl.done && rdy_mode && cmp_on) begin
      if (q.act.single_shot) begin
        d.rdy_hold = 1'b1;
      end else begin
        d.rdy_cnt =
          adc_ctrl_pkg::RDY_CNT_W'(adc_ctrl_pkg::RDY_PULSE_CYC);
      end
    end

    // Pin: open drain, drive low only when that is the wanted level
    // The pin is never driven high; the pull-up gives the high level
    asserted = rdy_mode ? (d.rdy_cnt != '0 || d.rdy_hold) : d.alert;
    d.pin_o = 1'b0;
    d.pin_oe = cmp_on &&
               (q.cfg.alert_polarity ? !asserted : asserted);
    d.ara_respond = d.alert && latched && cmp_on;

    // Outputs that follow the active conversion settings and the sequencer state
    d.mux = adc_ctrl_pkg::mux_decode(d.act.input_select);
    d.gain = d.act.gain_range_select;
    d.busy = d.st == adc_ctrl_pkg::ST_CONV;
    d.idle = d.st == adc_ctrl_pkg::ST_IDLE;

    if (general_call_reset) begin
      d = CORE_RESET;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= CORE_RESET;
    end else begin
      q <= d;
    end
  end

  // Top outputs straight from the state register
  assign mux_pos_q = q.mux.pos;
  assign mux_neg_q = q.mux.neg;
  assign neg_to_gnd_q = q.mux.neg_to_gnd;
  assign gain_code_q = q.gain;

  // Modulator and conversion status
  assign modulator_clk_q = q.mod_clk;
  assign conv_busy_q = q.busy;
  assign op_status_idle_q = q.idle;
  assign result_q = q.result;

  // Alert pin and alert response
  assign alert_pin_o_q = q.pin_o;
  assign alert_pin_oe_q = q.pin_oe;
  assign ara_respond_q = q.ara_respond;
  assign ara_status_q = q.above;

endmodule

// file: adc_ctrl_pkg.sv
// Shared constants, types and decode functions for the converter control.
// Assumes a 10 MHz system clock standing in for the internal oscillator.
package adc_ctrl_pkg;

  // Clock and oscillator figures
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned OSC_HZ = 1_000_000;
  localparam int unsigned OSC_DIV = CLK_HZ / OSC_HZ;
  localparam int unsigned MOD_DIV = 4;
  localparam int unsigned MOD_HALF = MOD_DIV / 2;

  // Conversion-ready pulse length
  localparam int unsigned RDY_PULSE_NS = 8000;
  localparam int unsigned RDY_PULSE_CYC = RDY_PULSE_NS / CLK_PERIOD_NS;

  localparam int unsigned CONV_CNT_W = 21;
  localparam int unsigned RDY_CNT_W = 7;
  localparam int unsigned OSC_CNT_W = 4;

  // Queue field codes
  localparam logic [1:0] QUE_ONE = 2'h0;
  localparam logic [1:0] QUE_TWO = 2'h1;
  localparam logic [1:0] QUE_FOUR = 2'h2;
  localparam logic [1:0] QUE_OFF = 2'h3;
  localparam logic [2:0] NEED_ONE = 3'h1;
  localparam logic [2:0] NEED_TWO = 3'h2;
  localparam logic [2:0] NEED_FOUR = 3'h4;

  // Bit that marks ready signalling in the limit words
  localparam int unsigned LIMIT_MSB = 15;

  typedef struct packed {
    logic [2:0] input_select;
    logic [2:0] gain_range_select;
    logic [2:0] rate_select;
    logic single_shot;
    logic window_style;
    logic alert_polarity;
    logic alert_latch_enable;
    logic [1:0] alert_queue_count;
  } cfg_t;

  // Power-up configuration
  localparam cfg_t CFG_DEFAULT = '{
    input_select: 3'h0,
    gain_range_select: 3'h2,
    rate_select: 3'h4,
    single_shot: 1'h1,
    window_style: 1'h0,
    alert_polarity: 1'h0,
    alert_latch_enable: 1'h0,
    alert_queue_count: QUE_OFF
  };
  localparam logic [15:0] UPPER_DEFAULT = 16'h7fff;
  localparam logic [15:0] LOWER_DEFAULT = 16'h8000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_CONV = 2'h2
  } conv_state_t;

  typedef struct packed {
    logic [1:0] pos;
    logic [1:0] neg;
    logic neg_to_gnd;
  } mux_t;

  // Input pair for each selector code
  function automatic mux_t mux_decode(input logic [2:0] sel);
    mux_t m;
    m = '{pos: 2'h0, neg: 2'h1, neg_to_gnd: 1'h0};
    case (sel)
      3'h0: m = '{pos: 2'h0, neg: 2'h1, neg_to_gnd: 1'h0};
      3'h1: m = '{pos: 2'h0, neg: 2'h3, neg_to_gnd: 1'h0};
      3'h2: m = '{pos: 2'h1, neg: 2'h3, neg_to_gnd: 1'h0};
      3'h3: m = '{pos: 2'h2, neg: 2'h3, neg_to_gnd: 1'h0};
      default: m = '{pos: sel[1:0], neg: 2'h0, neg_to_gnd: 1'h1};
    endcase
    return m;
  endfunction

  // Output data rate in samples per second
  function automatic int unsigned rate_sps(input logic [2:0] rate);
    int unsigned s;
    s = 8;
    case (rate)
      3'h0: s = 8;
      3'h1: s = 16;
      3'h2: s = 32;
      3'h3: s = 64;
      3'h4: s = 128;
      3'h5: s = 250;
      3'h6: s = 475;
      default: s = 860;
    endcase
    return s;
  endfunction

  // Successive out-of-limit results needed per queue code
  function automatic logic [2:0] queue_need(input logic [1:0] que);
    logic [2:0] n;
    n = NEED_ONE;
    case (que)
      QUE_TWO: n = NEED_TWO;
      QUE_FOUR: n = NEED_FOUR;
      default: n = NEED_ONE;
    endcase
    return n;
  endfunction

endpackage

// file: adc_ctl_if.sv
// Internal carrier between the control core, its timer and its qualifier.
// Assumes all three sit on sys_clk.
`timescale 1ns/1ps
interface adc_ctl_if;
  logic soft_rst;
  logic start;
  logic [2:0] rate;
  logic busy;
  logic done;
  logic eval;
  logic outl;
  logic clr;
  logic [2:0] need;
  logic hit;

  modport tmr (input soft_rst, start, rate, output busy, done);
  modport qual (input soft_rst, eval, outl, clr, need, output hit);
  modport ctrl (output soft_rst, start, rate, eval, outl, clr, need,
                input busy, done, hit);
endinterface

// file: conv_timer.sv
// Conversion period timer: one conversion lasts one output-rate period.
// Assumes start is a one-cycle request from the control core.
`timescale 1ns/1ps
module conv_timer #(
  parameter int unsigned CONV_CLK_HZ = adc_ctrl_pkg::CLK_HZ
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  adc_ctl_if.tmr ctl
);

  typedef struct packed {
    logic busy;
    logic done;
    logic [adc_ctrl_pkg::CONV_CNT_W-1:0] cnt;
  } tmr_t;

  tmr_t q;
  tmr_t d;

  // Load period on start, count down, flag the end
  always_comb begin
    d = q;
    d.done = 1'b0;
    if (ctl.soft_rst) begin
      d = '0;
    end else if (!q.busy && ctl.start) begin
      d.busy = 1'b1;
      d.cnt = adc_ctrl_pkg::CONV_CNT_W'(CONV_CLK_HZ /
              adc_ctrl_pkg::rate_sps(ctl.rate) - 1);
    end else if (q.busy) begin
      if (q.cnt == '0) begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end else begin
        d.cnt = q.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign ctl.busy = q.busy;
  assign ctl.done = q.done;

endmodule

// file: alert_qualifier.sv
// Counts successive out-of-limit results and reports when enough are seen.
// Assumes eval pulses once for each completed conversion.
`timescale 1ns/1ps
module alert_qualifier (
  input wire logic sys_clk,
  input wire logic rst_n,
  adc_ctl_if.qual ctl
);

  typedef struct packed {
    logic [2:0] cnt;
  } qual_t;

  qual_t q;
  qual_t d;
  logic [2:0] next_cnt;

  // Saturating run length of out-of-limit results
  always_comb begin
    d = q;
    next_cnt = (q.cnt >= ctl.need) ? q.cnt : q.cnt + 3'h1;
    if (ctl.soft_rst || ctl.clr) begin
      d.cnt = 3'h0;
    end else if (ctl.eval) begin
      d.cnt = ctl.outl ? next_cnt : 3'h0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Qualified in the cycle of the result that completes the run
  assign ctl.hit = ctl.eval && ctl.outl && !ctl.clr &&
                   (next_cnt >= ctl.need);

endmodule

// file: adc_ctrl_asserts.sv
// Port-level assertions for the converter control core.
// Assumes binding into adc_conv_alert_ctrl, one sys_clk domain.
`timescale 1ns/1ps
module adc_ctrl_asserts (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cfg_write,
  input wire logic limit_write,
  input wire logic [1:0] alert_queue_count,
  input wire logic op_status_start,
  input wire logic general_call_reset,
  input wire logic result_read,
  input wire logic ara_won,
  input wire logic [15:0] filter_result,
  input wire logic [1:0] mux_pos_q,
  input wire logic [1:0] mux_neg_q,
  input wire logic neg_to_gnd_q,
  input wire logic [2:0] gain_code_q,
  input wire logic modulator_clk_q,
  input wire logic conv_busy_q,
  input wire logic op_status_idle_q,
  input wire logic [15:0] result_q,
  input wire logic alert_pin_o_q,
  input wire logic alert_pin_oe_q,
  input wire logic ara_respond_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Modulator clock steps and comparator-off steps
  sequence s_mod_period;
    ##20 $fell(modulator_clk_q) ##20 $rose(modulator_clk_q);
  endsequence
  sequence s_off_cfg;
    cfg_write && alert_queue_count == adc_ctrl_pkg::QUE_OFF ##1 !cfg_write;
  endsequence
  // Properties tying outputs to their causes
  property p_mod_clk;
    // Soft reset restarts the divider mid-period
    disable iff (!rst_n || general_call_reset)
    $rose(modulator_clk_q) |-> s_mod_period;
  endproperty
  property p_gnd;
    neg_to_gnd_q |-> mux_neg_q == 2'h0;
  endproperty
  property p_start;
    op_status_idle_q && op_status_start && !general_call_reset
      |=> conv_busy_q && !op_status_idle_q;
  endproperty
  property p_idle;
    op_status_idle_q != conv_busy_q;
  endproperty
  property p_off;
    s_off_cfg |=> !alert_pin_oe_q [*3];
  endproperty
  property p_od;
    alert_pin_o_q == 1'h0;
  endproperty
  property p_result;
    $fell(conv_busy_q) && !$past(general_call_reset)
      |-> result_q == $past(filter_result);
  endproperty
  property p_clear;
    ara_respond_q && (ara_won || result_read) && op_status_idle_q
      && !op_status_start |=> !ara_respond_q;
  endproperty
  property p_hold;
    ara_respond_q && !ara_won && !result_read && !general_call_reset
      && op_status_idle_q && !cfg_write && !$past(cfg_write)
      && !limit_write && !$past(limit_write)
      |=> ara_respond_q;
  endproperty
  property p_gcr;
    general_call_reset |=> op_status_idle_q && !conv_busy_q
      && !alert_pin_oe_q && !ara_respond_q && gain_code_q == 3'h2
      && mux_pos_q == 2'h0 && mux_neg_q == 2'h1 && result_q == 16'h0;
  endproperty
  a_mod_clk: assert property (p_mod_clk)
    else $error("modulator clock period wrong");
  a_gnd: assert property (p_gnd)
    else $error("grounded negative input not index 0");
  a_start: assert property (p_start)
    else $error("start not taken when idle");
  a_idle: assert property (p_idle)
    else $error("idle flag disagrees with busy");
  a_off: assert property (p_off)
    else $error("pin driven with comparator off");
  a_od: assert property (p_od)
    else $error("open drain data not low");
  a_result: assert property (p_result)
    else $error("result not sampled at conversion end");
  a_clear: assert property (p_clear)
    else $error("latched alert not cleared");
  a_hold: assert property (p_hold)
    else $error("latched alert dropped");
  a_gcr: assert property (p_gcr)
    else $error("general call reset state wrong");
endmodule

bind adc_conv_alert_ctrl adc_ctrl_asserts u_adc_ctrl_asserts (
  .sys_clk(sys_clk), .rst_n(rst_n), .cfg_write(cfg_write),
  .limit_write(limit_write),
  .alert_queue_count(alert_queue_count),
  .op_status_start(op_status_start),
  .general_call_reset(general_call_reset), .result_read(result_read),
  .ara_won(ara_won), .filter_result(filter_result),
  .mux_pos_q(mux_pos_q), .mux_neg_q(mux_neg_q),
  .neg_to_gnd_q(neg_to_gnd_q), .gain_code_q(gain_code_q),
  .modulator_clk_q(modulator_clk_q), .conv_busy_q(conv_busy_q),
  .op_status_idle_q(op_status_idle_q), .result_q(result_q),
  .alert_pin_o_q(alert_pin_o_q), .alert_pin_oe_q(alert_pin_oe_q),
  .ara_respond_q(ara_respond_q)
);

// file: i2c_ctrl_model.sv
// Bus controller stand-in: pull-up on the alert line, alert responses.
// Assumes the device pin comes split into data and enable.
`timescale 1ns/1ps
module i2c_ctrl_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ara_enable,
  input wire logic alert_pin_o_q,
  input wire logic alert_pin_oe_q,
  input wire logic ara_respond_q,
  output logic alert_wire,
  output logic ara_won
);
  // Pull-up wins unless the device pulls low
  assign alert_wire = alert_pin_oe_q ? alert_pin_o_q : 1'h1;
  // Repeat the response while the target still answers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ara_won <= 1'h0;
    end else begin
      ara_won <= ara_enable && ara_respond_q && !ara_won;
    end
  end
endmodule

// file: testbench.sv
// Self-checking bench for the converter control core.
// Assumes package, carrier, partner model and checker compile first.
`timescale 1ns/1ps
module testbench;
  localparam int unsigned CONV_HZ = 8600;
  logic sys_clk = 1'h0, rst_n = 1'h0, cfg_write = 1'h0, single_shot = 1'h1;
  logic window_style = 1'h0, alert_polarity = 1'h0, limit_write = 1'h0;
  logic alert_latch_enable = 1'h0, op_status_start = 1'h0, ara_en = 1'h0;
  logic general_call_reset = 1'h0, result_read = 1'h0;
  logic [2:0] input_select = 3'h0, gain_range_select = 3'h2;
  logic [2:0] rate_select = 3'h4, gain_code_q;
  logic [1:0] alert_queue_count = 2'h3, mux_pos_q, mux_neg_q;
  logic [15:0] upper_limit_in = 16'h7fff, lower_limit_in = 16'h8000;
  logic [15:0] filter_result = 16'h0, result_q;
  logic neg_to_gnd_q, modulator_clk_q, conv_busy_q, op_status_idle_q;
  logic alert_pin_o_q, alert_pin_oe_q, ara_respond_q, ara_status_q;
  logic ara_won, alert_wire;
  int n_errors = 0, checks = 0, n;
  int sps [8] = '{8, 16, 32, 64, 128, 250, 475, 860};
  logic [4:0] mux_tab [8] = '{5'h02, 5'h06, 5'h0e, 5'h16,
                              5'h01, 5'h09, 5'h11, 5'h19};
  logic [15:0] tv [4] = '{16'h00c8, 16'h00c8, 16'h0000, 16'hff38};
  logic tw [4] = '{1'h1, 1'h0, 1'h0, 1'h1};

  adc_conv_alert_ctrl #(.CONV_CLK_HZ(CONV_HZ)) u_adc_conv_alert_ctrl (
    .sys_clk(sys_clk), .rst_n(rst_n), .cfg_write(cfg_write),
    .input_select(input_select), .gain_range_select(gain_range_select),
    .rate_select(rate_select), .single_shot(single_shot),
    .window_style(window_style), .alert_polarity(alert_polarity),
    .alert_latch_enable(alert_latch_enable),
    .alert_queue_count(alert_queue_count), .limit_write(limit_write),
    .upper_limit_in(upper_limit_in), .lower_limit_in(lower_limit_in),
    .op_status_start(op_status_start),
    .general_call_reset(general_call_reset), .result_read(result_read),
    .ara_won(ara_won), .filter_result(filter_result),
    .mux_pos_q(mux_pos_q), .mux_neg_q(mux_neg_q),
    .neg_to_gnd_q(neg_to_gnd_q), .gain_code_q(gain_code_q),
    .modulator_clk_q(modulator_clk_q), .conv_busy_q(conv_busy_q),
    .op_status_idle_q(op_status_idle_q), .result_q(result_q),
    .alert_pin_o_q(alert_pin_o_q), .alert_pin_oe_q(alert_pin_oe_q),
    .ara_respond_q(ara_respond_q), .ara_status_q(ara_status_q));
  i2c_ctrl_model u_i2c_ctrl_model (.sys_clk(sys_clk), .rst_n(rst_n),
    .ara_enable(ara_en), .alert_pin_o_q(alert_pin_o_q),
    .alert_pin_oe_q(alert_pin_oe_q), .ara_respond_q(ara_respond_q),
    .alert_wire(alert_wire), .ara_won(ara_won));

  // Clock
  always #50 sys_clk = ~sys_clk;

  // Compare and verdict
  task automatic chk(input string what, input logic [15:0] exp, got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic pin(input logic exp);
    chk("alert pin", {15'h0, exp}, {15'h0, alert_wire});
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Config and limit writes, one-cycle strobes
  task automatic cfg(input logic [2:0] sel, gn, rt,
                     input logic ss, win, pol, lat, input logic [1:0] que);
    @(posedge sys_clk);
    cfg_write <= 1'h1;
    input_select <= sel;
    gain_range_select <= gn;
    rate_select <= rt;
    single_shot <= ss;
    window_style <= win;
    alert_polarity <= pol;
    alert_latch_enable <= lat;
    alert_queue_count <= que;
    @(posedge sys_clk);
    cfg_write <= 1'h0;
  endtask
  task automatic lim(input logic [15:0] up, lo);
    @(posedge sys_clk);
    limit_write <= 1'h1;
    upper_limit_in <= up;
    lower_limit_in <= lo;
    @(posedge sys_clk);
    limit_write <= 1'h0;
  endtask
  // Single-shot conversion, second start while busy; n = busy cycles
  task automatic conv(input logic [15:0] val);
    @(posedge sys_clk);
    filter_result <= val;
    op_status_start <= 1'h1;
    @(posedge sys_clk);
    op_status_start <= 1'h0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
      op_status_start <= (n == 3);
      #1;
    end while (conv_busy_q === 1'h1 && n < 3000);
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    stop_test();
  end

  // Test sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'h1;
    #1;
    chk("idle", 16'h1, {15'h0, op_status_idle_q});
    chk("gain", 16'h2, {13'h0, gain_code_q});
    pin(1'h1);
    $display("test reset done");
    for (int k = 0; k < 8; k++) begin
      cfg(k[2:0], k[2:0], k[2:0], 1'h1, 1'h0, 1'h0, 1'h0, 2'h3);
      conv(16'h1234);
      chk("busy cycles", 16'(CONV_HZ / sps[k] + 1), n[15:0]);
      chk("mux", {11'h0, mux_tab[k]},
          {11'h0, mux_pos_q, mux_neg_q, neg_to_gnd_q});
      chk("gain", {13'h0, k[2:0]}, {13'h0, gain_code_q});
      chk("result", 16'h1234, result_q);
    end
    $display("test select done");
    lim(16'h0064, 16'hff9c);
    cfg(3'h0, 3'h2, 3'h7, 1'h1, 1'h0, 1'h0, 1'h0, 2'h1);
    for (int i = 0; i < 4; i++) begin
      conv(tv[i]);
      pin(tw[i]);
    end
    $display("test traditional done");
    cfg(3'h0, 3'h2, 3'h7, 1'h1, 1'h1, 1'h1, 1'h1, 2'h0);
    conv(16'hff38);
    pin(1'h1);
    chk("ara status", 16'h0, {15'h0, ara_status_q});
    conv(16'h0000);
    chk("ara respond", 16'h1, {15'h0, ara_respond_q});
    ara_en <= 1'h1;
    for (int i = 0; i < 20 && ara_respond_q !== 1'h0; i++) begin
      @(posedge sys_clk);
      #1;
    end
    @(posedge sys_clk);
    ara_en <= 1'h0;
    #1;
    chk("ara respond", 16'h0, {15'h0, ara_respond_q});
    pin(1'h0);
    conv(16'h00c8);
    chk("ara respond", 16'h1, {15'h0, ara_respond_q});
    chk("ara status", 16'h1, {15'h0, ara_status_q});
    @(posedge sys_clk);
    result_read <= 1'h1;
    @(posedge sys_clk);
    result_read <= 1'h0;
    @(posedge sys_clk);
    #1;
    chk("ara respond", 16'h0, {15'h0, ara_respond_q});
    $display("test window done");
    cfg(3'h0, 3'h2, 3'h3, 1'h0, 1'h1, 1'h0, 1'h1, 2'h0);
    lim(16'h8000, 16'h0000);
    for (int i = 0; i < 400 && alert_wire !== 1'h0; i++) begin
      @(posedge sys_clk);
      #1;
    end
    n = 0;
    while (alert_wire === 1'h0 && n < 200) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk("ready pulse", 16'(adc_ctrl_pkg::RDY_PULSE_CYC),
        n[15:0]);
    cfg(3'h0, 3'h3, 3'h7, 1'h1, 1'h0, 1'h0, 1'h0, 2'h0);
    #1;
    chk("busy", 16'h1, {15'h0, conv_busy_q});
    chk("gain", 16'h2, {13'h0, gain_code_q});
    repeat (300) @(posedge sys_clk);
    conv(16'h0000);
    pin(1'h0);
    chk("gain", 16'h3, {13'h0, gain_code_q});
    cfg(3'h0, 3'h2, 3'h7, 1'h1, 1'h0, 1'h0, 1'h0, 2'h3);
    repeat (3) @(posedge sys_clk);
    #1;
    pin(1'h1);
    $display("test ready done");
    cfg(3'h0, 3'h5, 3'h0, 1'h1, 1'h0, 1'h0, 1'h0, 2'h3);
    @(posedge sys_clk);
    op_status_start <= 1'h1;
    @(posedge sys_clk);
    op_status_start <= 1'h0;
    repeat (5) @(posedge sys_clk);
    general_call_reset <= 1'h1;
    @(posedge sys_clk);
    general_call_reset <= 1'h0;
    #1;
    chk("idle", 16'h1, {15'h0, op_status_idle_q});
    chk("gain", 16'h2, {13'h0, gain_code_q});
    $display("test general reset done");
    stop_test();
  end
endmodule
